// ===== common/cpl_pkg.sv
// cpl_pkg: constants for the cassette program loader.
// assumes a single 200 MHz system clock and a synchronous active-high reset.
package cpl_pkg;
   // clock and times
   localparam int unsigned CLK_HZ          = 200_000_000;
   localparam int unsigned BLINK_HALF_MS   = 250;
   localparam int unsigned DEBOUNCE_MS     = 10;
   localparam int unsigned BLINK_CYCLES    = (CLK_HZ / 1000) * BLINK_HALF_MS;
   localparam int unsigned DEBOUNCE_CYCLES = (CLK_HZ / 1000) * DEBOUNCE_MS;

   // memory word shape
   localparam int MEM_AW = 15;
   localparam int MEM_DW = 16;

   // avalon register map, byte addresses
   localparam int          BUS_AW       = 8;
   localparam logic [7:0]  REG_CTRL     = 8'h00;
   localparam logic [7:0]  REG_STATUS   = 8'h04;
   localparam logic [7:0]  REG_XFER_LEN = 8'h08;
   localparam logic [7:0]  REG_NVM_WR   = 8'h0c;
   localparam logic [7:0]  REG_SKIPPED  = 8'h10;

   // control bits
   localparam int CTRL_DISP_WR  = 0;
   localparam int CTRL_DISP_RD  = 1;
   // status bits
   localparam int STAT_STATE_LO = 0;
   localparam int STAT_LOCK     = 4;
   localparam int STAT_DISPLAY  = 5;
   localparam int STAT_PRESENT  = 6;
   localparam int STAT_RUNNING  = 7;
   localparam int STAT_ERR      = 8;
   localparam int STAT_DONE     = 9;
   localparam int STAT_PENDING  = 10;

   // reset values
   localparam logic [MEM_AW-1:0] XFER_LEN_RST = 15'h4000;

   // program-memory operation kinds
   localparam logic [1:0] OP_BLOCK_MOVE      = 2'h0;
   localparam logic [1:0] OP_BLOCK_MOVE_EDGE = 2'h1;
   localparam logic [1:0] OP_EXT_FILE_REG_RW = 2'h2;
   localparam logic [1:0] OP_PERIPH_WRITE    = 2'h3;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_ARM_W  = 3'b001,
      ST_ARM_R  = 3'b010,
      ST_SRC    = 3'b011,
      ST_CMP    = 3'b100,
      ST_DST    = 3'b101,
      ST_COMMIT = 3'b110
   } cpl_state_e;
endpackage

// ===== src/cpl_loader.sv
// cpl_loader: two-key program loader between a plug-in cassette and the unit's memories.
// assumes key, cassette and display pins are asynchronous; all other inputs are on CLK_SYS_IN.
//
// Summary of operation
// (R01) keys start transfers only while stopped.
// (R02) write copy: cassette image into nonvolatile program memory.
// (R03) read copy: working memory into the cassette.
// (R04) first write press from idle: write led steady, armed, no data.
// (R05) read press while write-armed: cancel, idle, write led off.
// (R06) second write press starts copy; write led blinks.
// (R07) write copy done: write led off, idle.
// (R08) first read press from idle: read led steady, armed, no data.
// (R09) write press while read-armed: cancel, idle, read led off.
// (R10) second read press starts copy; read led blinks.
// (R11) read copy done: read led off, idle.
// (R12) read copy needs cassette unlocked and controller stopped.
// (R13) cassette writes blocked while locked.
// (R14) display attached: keys move nothing; display commands start transfers.
// (R15) one cassette port; transfers need the cassette present.
// (R16) skip nonvolatile writes of words already stored.
// (R17) continuous block move commits each scan; edge form once.
// (R18) peripheral file-register writes also commit to nonvolatile memory.
// (R19) extended file register access commits only on request edge.
// (R20) during a copy both keys are ignored.
//
// The register addresses and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module cpl_loader #(
   parameter int unsigned BLINK_CYCLES    = cpl_pkg::BLINK_CYCLES,
   parameter int unsigned DEBOUNCE_CYCLES = cpl_pkg::DEBOUNCE_CYCLES
) (
   input  wire logic                       CLK_SYS_IN,
   input  wire logic                       RST_IN,
   // operator pins
   input  wire logic                       WR_KEY_IN,
   input  wire logic                       RD_KEY_IN,
   output logic                            WR_LED_OUT,
   output logic                            RD_LED_OUT,
   input  wire logic                       CASS_LOCK_IN,
   input  wire logic                       CASS_PRESENT_IN,
   input  wire logic                       DISPLAY_ATTACHED_IN,
   input  wire logic                       CTRL_RUN_IN,
   // cassette memory
   output logic                            CASS_RD_OUT,
   output logic                            CASS_WR_OUT,
   output logic [cpl_pkg::MEM_AW-1:0]      CASS_ADDR_OUT,
   output logic [cpl_pkg::MEM_DW-1:0]      CASS_WDATA_OUT,
   input  wire logic [cpl_pkg::MEM_DW-1:0] CASS_RDATA_IN,
   input  wire logic                       CASS_ACK_IN,
   // program memory
   output logic                            NVM_RD_OUT,
   output logic                            NVM_WR_OUT,
   output logic [cpl_pkg::MEM_AW-1:0]      NVM_ADDR_OUT,
   output logic [cpl_pkg::MEM_DW-1:0]      NVM_WDATA_OUT,
   input  wire logic [cpl_pkg::MEM_DW-1:0] NVM_RDATA_IN,
   input  wire logic                       NVM_ACK_IN,
   // working memory
   output logic                            RAM_RD_OUT,
   output logic [cpl_pkg::MEM_AW-1:0]      RAM_ADDR_OUT,
   input  wire logic [cpl_pkg::MEM_DW-1:0] RAM_RDATA_IN,
   input  wire logic                       RAM_ACK_IN,
   // program-memory ops
   input  wire logic                       SCAN_IN,
   input  wire logic                       OP_VALID_IN,
   input  wire logic [1:0]                 OP_KIND_IN,
   input  wire logic [cpl_pkg::MEM_AW-1:0] OP_ADDR_IN,
   input  wire logic [cpl_pkg::MEM_DW-1:0] OP_DATA_IN,
   // avalon-mm slave
   input  wire logic [cpl_pkg::BUS_AW-1:0] AVS_ADDRESS_IN,
   input  wire logic                       AVS_READ_IN,
   input  wire logic                       AVS_WRITE_IN,
   input  wire logic [3:0]                 AVS_BYTEENABLE_IN,
   input  wire logic [31:0]                AVS_WRITEDATA_IN,
   output logic [31:0]                     AVS_READDATA_OUT,
   output logic                            AVS_WAITREQUEST_OUT
);
   logic [4:0] pin_raw;
   logic [4:0] sync1_q;
   logic [4:0] sync2_q;
   assign pin_raw = {DISPLAY_ATTACHED_IN, CASS_PRESENT_IN, CASS_LOCK_IN, RD_KEY_IN, WR_KEY_IN};
   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         sync1_q <= 5'h00;
         sync2_q <= 5'h00;
      end else begin
         sync1_q <= pin_raw;
         sync2_q <= sync1_q;
      end
   end
   wire lock_s    = sync2_q[2];
   wire present_s = sync2_q[3];
   wire display_s = sync2_q[4];

   logic [1:0] key_db_q;
   logic [1:0] key_prev_q;
   logic [1:0] key_press;
   genvar gk;
   generate
      for (gk = 0; gk < 2; gk++) begin : g_key
         logic [31:0] cnt_q;
         always_ff @(posedge CLK_SYS_IN) begin
            if (RST_IN) begin
               cnt_q         <= 32'h0;
               key_db_q[gk]  <= 1'b0;
            end else if (sync2_q[gk] == key_db_q[gk]) begin
               cnt_q <= 32'h0;
            end else if (cnt_q >= DEBOUNCE_CYCLES - 1) begin
               cnt_q        <= 32'h0;
               key_db_q[gk] <= sync2_q[gk];
            end else begin
               cnt_q <= cnt_q + 32'h1;
            end
         end
      end
   endgenerate
   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         key_prev_q <= 2'h0;
      end else begin
         key_prev_q <= key_db_q;
      end
   end
   assign key_press = key_db_q & ~key_prev_q;
   // keys count only when stopped, cassette fitted, no display module
   wire keys_live = ~CTRL_RUN_IN & present_s & ~display_s;                 // (R01) (R14) (R15)
   wire ev_wr     = key_press[0] & keys_live;
   wire ev_rd     = key_press[1] & keys_live;

   cpl_pkg::cpl_state_e st_q;
   cpl_pkg::cpl_state_e st_d;
   logic                       dir_wr_q;
   logic                       dir_wr_d;
   logic [cpl_pkg::MEM_AW-1:0] addr_q;
   logic [cpl_pkg::MEM_AW-1:0] addr_d;
   logic [cpl_pkg::MEM_DW-1:0] data_q;
   logic [cpl_pkg::MEM_DW-1:0] data_d;
   logic [cpl_pkg::MEM_AW-1:0] xfer_len_q;
   logic [31:0]                nvm_wr_cnt_q;
   logic [31:0]                skipped_cnt_q;
   logic                       err_q;
   logic                       done_q;
   logic                       bus_ack_q;
   logic [31:0]                rdata_q;
   logic                       pend_q;
   wire bus_req     = AVS_READ_IN | AVS_WRITE_IN;
   wire bus_take    = bus_req & ~bus_ack_q;
   wire wr_take     = AVS_WRITE_IN & ~bus_ack_q;
   wire sel_ctrl    = AVS_ADDRESS_IN == cpl_pkg::REG_CTRL;
   wire sel_status  = AVS_ADDRESS_IN == cpl_pkg::REG_STATUS;
   wire sel_len     = AVS_ADDRESS_IN == cpl_pkg::REG_XFER_LEN;
   wire sel_nvm     = AVS_ADDRESS_IN == cpl_pkg::REG_NVM_WR;
   wire sel_skip    = AVS_ADDRESS_IN == cpl_pkg::REG_SKIPPED;
   wire wr_ctrl     = wr_take & sel_ctrl & AVS_BYTEENABLE_IN[0];
   wire wr_status   = wr_take & sel_status & AVS_BYTEENABLE_IN[1];
   wire wr_len_lo   = wr_take & sel_len & AVS_BYTEENABLE_IN[0];
   wire wr_len_hi   = wr_take & sel_len & AVS_BYTEENABLE_IN[1];

   // display path is the only start while attached
   wire disp_ok     = display_s & ~CTRL_RUN_IN & present_s;                // (R14) (R01)
   wire cmd_wr      = wr_ctrl & AVS_WRITEDATA_IN[cpl_pkg::CTRL_DISP_WR] & disp_ok;
   wire cmd_rd      = wr_ctrl & AVS_WRITEDATA_IN[cpl_pkg::CTRL_DISP_RD] & disp_ok;
   wire [31:0] status_word = {21'h0, pend_q, done_q, err_q, CTRL_RUN_IN,
                              present_s, display_s, lock_s, 1'b0, st_q};

   wire [31:0] rd_mux = sel_status ? status_word :
                        sel_len    ? {17'h0, xfer_len_q} :
                        sel_nvm    ? nvm_wr_cnt_q :
                        sel_skip   ? skipped_cnt_q : 32'h0;

   assign AVS_WAITREQUEST_OUT = bus_req & ~bus_ack_q;
   assign AVS_READDATA_OUT    = rdata_q;
   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         bus_ack_q  <= 1'b0;
         rdata_q    <= 32'h0;
         xfer_len_q <= cpl_pkg::XFER_LEN_RST;
      end else begin
         bus_ack_q <= bus_take;
         if (bus_take && AVS_READ_IN) rdata_q <= rd_mux;
         if (wr_len_lo) xfer_len_q[7:0] <= AVS_WRITEDATA_IN[7:0];
         if (wr_len_hi) xfer_len_q[14:8] <= AVS_WRITEDATA_IN[14:8];
      end
   end

   logic                       op_prev_q;
   logic [cpl_pkg::MEM_AW-1:0] pend_addr_q;
   logic [cpl_pkg::MEM_DW-1:0] pend_data_q;
   wire op_rise   = OP_VALID_IN & ~op_prev_q;
   wire op_cont   = OP_KIND_IN == cpl_pkg::OP_BLOCK_MOVE;
   wire op_trig   = op_cont ? (OP_VALID_IN & SCAN_IN)                     // (R17)
                            : op_rise;                                     // (R17) (R18) (R19)
   wire commit_ack = (st_q == cpl_pkg::ST_COMMIT) & NVM_ACK_IN;

   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         op_prev_q   <= 1'b0;
         pend_q      <= 1'b0;
         pend_addr_q <= 15'h0;
         pend_data_q <= 16'h0;
      end else begin
         op_prev_q <= OP_VALID_IN;
         if (op_trig) begin
            pend_q      <= 1'b1;
            pend_addr_q <= OP_ADDR_IN;
            pend_data_q <= OP_DATA_IN;
         end else if (commit_ack) pend_q <= 1'b0;
      end
   end

   wire last_word = addr_q == xfer_len_q - 15'h1;
   wire rd_block  = ~dir_wr_q & (lock_s | CTRL_RUN_IN);                    // (R12)
   logic set_err, set_done, nvm_wr_ack, skip_hit;

   always_comb begin
      st_d       = st_q;
      dir_wr_d   = dir_wr_q;
      addr_d     = addr_q;
      data_d     = data_q;
      set_err    = 1'b0;
      set_done   = 1'b0;
      nvm_wr_ack = 1'b0;
      skip_hit   = 1'b0;
      case (st_q)
         cpl_pkg::ST_IDLE: begin
            addr_d = 15'h0;
            if (ev_wr) begin
               st_d = cpl_pkg::ST_ARM_W;                                   // (R04)
            end else if (ev_rd) begin
               st_d = cpl_pkg::ST_ARM_R;                                   // (R08)
            end else if (cmd_wr) begin
               st_d     = cpl_pkg::ST_SRC;                                 // (R14)
               dir_wr_d = 1'b1;
            end else if (cmd_rd) begin
               if (lock_s) begin
                  set_err = 1'b1;                                          // (R12)
               end else begin
                  st_d     = cpl_pkg::ST_SRC;
                  dir_wr_d = 1'b0;
               end
            end else if (pend_q && !op_trig) begin
               st_d   = cpl_pkg::ST_COMMIT;
               addr_d = pend_addr_q;
               data_d = pend_data_q;
            end
         end
         cpl_pkg::ST_ARM_W: begin
            if (!keys_live && !display_s) begin
               st_d = cpl_pkg::ST_IDLE;
            end else if (ev_rd) begin
               st_d = cpl_pkg::ST_IDLE;                                    // (R05)
            end else if (ev_wr) begin
               st_d     = cpl_pkg::ST_SRC;                                 // (R06)
               dir_wr_d = 1'b1;
            end
         end
         cpl_pkg::ST_ARM_R: begin
            if (!keys_live && !display_s) begin
               st_d = cpl_pkg::ST_IDLE;
            end else if (ev_wr) begin
               st_d = cpl_pkg::ST_IDLE;                                    // (R09)
            end else if (ev_rd) begin
               if (lock_s) begin
                  st_d    = cpl_pkg::ST_IDLE;                              // (R12)
                  set_err = 1'b1;
               end else begin
                  st_d     = cpl_pkg::ST_SRC;                              // (R10)
                  dir_wr_d = 1'b0;
               end
            end
         end
         cpl_pkg::ST_SRC: begin
            if (!present_s || rd_block) begin
               st_d    = cpl_pkg::ST_IDLE;                                 // (R12) (R15)
               set_err = 1'b1;
            end else if (dir_wr_q && CASS_ACK_IN) begin
               data_d = CASS_RDATA_IN;                                     // (R02)
               st_d   = cpl_pkg::ST_CMP;
            end else if (!dir_wr_q && RAM_ACK_IN) begin
               data_d = RAM_RDATA_IN;                                      // (R03)
               st_d   = cpl_pkg::ST_DST;
            end
         end
         cpl_pkg::ST_CMP: begin
            if (!present_s) begin
               st_d    = cpl_pkg::ST_IDLE;
               set_err = 1'b1;
            end else if (NVM_ACK_IN) begin
               if (NVM_RDATA_IN == data_q) begin
                  skip_hit = 1'b1;                                         // (R16)
                  if (last_word) begin
                     st_d     = cpl_pkg::ST_IDLE;                          // (R07)
                     set_done = 1'b1;
                  end else begin
                     addr_d = addr_q + 15'h1;
                     st_d   = cpl_pkg::ST_SRC;
                  end
               end else begin
                  st_d = cpl_pkg::ST_DST;
               end
            end
         end
         cpl_pkg::ST_DST: begin
            if (!present_s || rd_block) begin
               st_d    = cpl_pkg::ST_IDLE;                                 // (R13)
               set_err = 1'b1;
            end else if ((dir_wr_q && NVM_ACK_IN) || (!dir_wr_q && CASS_ACK_IN)) begin
               nvm_wr_ack = dir_wr_q;
               if (last_word) begin
                  st_d     = cpl_pkg::ST_IDLE;                             // (R07) (R11)
                  set_done = 1'b1;
               end else begin
                  addr_d = addr_q + 15'h1;
                  st_d   = cpl_pkg::ST_SRC;
               end
            end
         end
         cpl_pkg::ST_COMMIT: begin
            if (NVM_ACK_IN) begin
               nvm_wr_ack = 1'b1;
               st_d       = cpl_pkg::ST_IDLE;
            end
         end
         default: begin
            st_d = cpl_pkg::ST_IDLE;
         end
      endcase
   end
   // copy states never read key events (R20)
   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         st_q     <= cpl_pkg::ST_IDLE;
         dir_wr_q <= 1'b0;
         addr_q   <= 15'h0;
         data_q   <= 16'h0;
      end else begin
         st_q     <= st_d;
         dir_wr_q <= dir_wr_d;
         addr_q   <= addr_d;
         data_q   <= data_d;
      end
   end
   // sticky flags, hardware set wins over a write-one clear
   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         err_q         <= 1'b0;
         done_q        <= 1'b0;
         nvm_wr_cnt_q  <= 32'h0;
         skipped_cnt_q <= 32'h0;
      end else begin
         if (set_err) err_q <= 1'b1;
         else if (wr_status && AVS_WRITEDATA_IN[cpl_pkg::STAT_ERR]) err_q <= 1'b0;
         if (set_done) done_q <= 1'b1;
         else if (wr_status && AVS_WRITEDATA_IN[cpl_pkg::STAT_DONE]) done_q <= 1'b0;
         if (nvm_wr_ack) nvm_wr_cnt_q <= nvm_wr_cnt_q + 32'h1;
         if (skip_hit) skipped_cnt_q <= skipped_cnt_q + 32'h1;
      end
   end

   wire in_src = st_q == cpl_pkg::ST_SRC;
   wire in_dst = st_q == cpl_pkg::ST_DST;
   assign CASS_RD_OUT    = in_src & dir_wr_q;
   assign RAM_RD_OUT     = in_src & ~dir_wr_q;
   assign CASS_WR_OUT    = in_dst & ~dir_wr_q & ~lock_s;                   // (R13)
   assign NVM_RD_OUT     = st_q == cpl_pkg::ST_CMP;
   assign NVM_WR_OUT     = (in_dst & dir_wr_q) | (st_q == cpl_pkg::ST_COMMIT);
   assign CASS_ADDR_OUT  = addr_q;
   assign NVM_ADDR_OUT   = addr_q;
   assign RAM_ADDR_OUT   = addr_q;
   assign CASS_WDATA_OUT = data_q;
   assign NVM_WDATA_OUT  = data_q;

   wire copying = in_src | in_dst | (st_q == cpl_pkg::ST_CMP);
   logic [31:0] blink_cnt_q;
   logic        blink_q;

   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         blink_cnt_q <= 32'h0;
         blink_q     <= 1'b0;
         WR_LED_OUT  <= 1'b0;
         RD_LED_OUT  <= 1'b0;
      end else begin
         if (!copying) begin
            blink_cnt_q <= 32'h0;
            blink_q     <= 1'b1;
         end else if (blink_cnt_q >= BLINK_CYCLES - 1) begin
            blink_cnt_q <= 32'h0;
            blink_q     <= ~blink_q;
         end else begin
            blink_cnt_q <= blink_cnt_q + 32'h1;
         end
         WR_LED_OUT <= (st_q == cpl_pkg::ST_ARM_W) | (copying & dir_wr_q & blink_q);   // (R04) (R06)
         RD_LED_OUT <= (st_q == cpl_pkg::ST_ARM_R) | (copying & ~dir_wr_q & blink_q);  // (R08) (R10)
      end
   end

endmodule // cpl_loader
`default_nettype wire

// ===== tb/cpl_loader_asserts.sv
// cpl_loader_asserts: port timing checks for the loader.
// assumes one clock and a synchronous active-high reset; bound into every cpl_loader.
`timescale 1ns/1ps
`default_nettype none
module cpl_loader_asserts (
   input wire logic                       CLK_SYS_IN,
   input wire logic                       RST_IN,
   input wire logic                       WR_LED_OUT,
   input wire logic                       RD_LED_OUT,
   input wire logic                       CASS_LOCK_IN,
   input wire logic                       CTRL_RUN_IN,
   input wire logic                       CASS_RD_OUT,
   input wire logic                       CASS_WR_OUT,
   input wire logic [cpl_pkg::MEM_AW-1:0] CASS_ADDR_OUT,
   input wire logic [cpl_pkg::MEM_DW-1:0] CASS_WDATA_OUT,
   input wire logic                       CASS_ACK_IN,
   input wire logic                       NVM_RD_OUT,
   input wire logic                       NVM_WR_OUT,
   input wire logic [cpl_pkg::MEM_AW-1:0] NVM_ADDR_OUT,
   input wire logic                       NVM_ACK_IN,
   input wire logic                       RAM_RD_OUT,
   input wire logic [cpl_pkg::MEM_AW-1:0] RAM_ADDR_OUT,
   input wire logic                       RAM_ACK_IN,
   input wire logic                       SCAN_IN,
   input wire logic                       OP_VALID_IN,
   input wire logic [1:0]                 OP_KIND_IN,
   input wire logic                       AVS_READ_IN,
   input wire logic                       AVS_WRITE_IN,
   input wire logic                       AVS_WAITREQUEST_OUT
);
   default clocking cb @(posedge CLK_SYS_IN); endclocking
   default disable iff (RST_IN);
   sequence s_one_wait;
      AVS_WAITREQUEST_OUT ##1 !AVS_WAITREQUEST_OUT;
   endsequence
   a_bus_one_wait: assert property ($rose(AVS_READ_IN || AVS_WRITE_IN) |-> s_one_wait)
      else $error("bus access not answered after one wait");
   a_lock_stops_wr: assert property ($past(CASS_LOCK_IN, 2) |-> !CASS_WR_OUT)
      else $error("cassette write while locked");
   a_run_stops_wr: assert property (CASS_WR_OUT |-> !$past(CTRL_RUN_IN, 3))
      else $error("cassette write while running");
   a_cass_wr_hold: assert property (CASS_WR_OUT && !CASS_ACK_IN |=> CASS_WR_OUT && $stable(CASS_ADDR_OUT) && $stable(CASS_WDATA_OUT))
      else $error("cassette write dropped before ack");
   a_nvm_rd_hold: assert property (NVM_RD_OUT && !NVM_ACK_IN |=> NVM_RD_OUT && $stable(NVM_ADDR_OUT))
      else $error("nvm read dropped before ack");
   a_ram_rd_hold: assert property (RAM_RD_OUT && !RAM_ACK_IN |=> RAM_RD_OUT && $stable(RAM_ADDR_OUT))
      else $error("ram read dropped before ack");
   a_one_cass_req: assert property (!(CASS_RD_OUT && CASS_WR_OUT))
      else $error("two cassette requests at once");
   a_wr_dir_only: assert property (WR_LED_OUT |-> !CASS_WR_OUT && !RAM_RD_OUT)
      else $error("write copy moved data the wrong way");
   a_rd_dir_only: assert property (RD_LED_OUT |-> !NVM_WR_OUT)
      else $error("read copy wrote nvm");
   a_scan_commit: assert property (SCAN_IN && OP_VALID_IN && OP_KIND_IN == cpl_pkg::OP_BLOCK_MOVE
      && !WR_LED_OUT && !RD_LED_OUT |-> ##[1:40] NVM_WR_OUT)
      else $error("continuous block move not committed");
endmodule // cpl_loader_asserts
bind cpl_loader cpl_loader_asserts u_chk (.*);
`default_nettype wire

// ===== tb/cpl_loader_bench.sv
// cpl_loader_bench: key, bus and operation sequences against cpl_loader and memory models.
// assumes short blink and debounce counts; memories answer after a settable wait.
`timescale 1ns/1ps
`default_nettype none
module cpl_loader_bench;
   logic clk = 1'b0, rst = 1'b1, wk = 1'b0, rk = 1'b0, lock = 1'b0, disp = 1'b0, run = 1'b0;
   logic scan = 1'b0, opv = 1'b0, rd = 1'b0, wr = 1'b0, wl_p = 1'b0;
   logic [1:0] kind = 2'h0;
   logic [14:0] oa = 15'h0000;
   logic [15:0] od = 16'h0000;
   logic [7:0] ba = 8'h00, lat = 8'h00;
   logic [3:0] be = 4'h0;
   logic [31:0] bd = 32'h0, q, rdo;
   logic cr, cw, nr, nw, rr, ca, na, ra, wl, rl, wq;
   logic [14:0] cad, nad, rad;
   logic [15:0] cwd, nwd, crd, nrd, rrd;
   int bad_count = 0, compares = 0, cyc = 0, wtog = 0, rhi = 0, cn, nn, k, t0, r0;
   initial forever #2.5 clk = ~clk;
   cpl_loader #(.BLINK_CYCLES(8), .DEBOUNCE_CYCLES(4)) dut (.CLK_SYS_IN(clk), .RST_IN(rst), .WR_KEY_IN(wk),
      .RD_KEY_IN(rk), .WR_LED_OUT(wl), .RD_LED_OUT(rl), .CASS_LOCK_IN(lock), .CASS_PRESENT_IN(1'b1),
      .DISPLAY_ATTACHED_IN(disp), .CTRL_RUN_IN(run), .CASS_RD_OUT(cr), .CASS_WR_OUT(cw), .CASS_ADDR_OUT(cad),
      .CASS_WDATA_OUT(cwd), .CASS_RDATA_IN(crd), .CASS_ACK_IN(ca), .NVM_RD_OUT(nr), .NVM_WR_OUT(nw),
      .NVM_ADDR_OUT(nad), .NVM_WDATA_OUT(nwd), .NVM_RDATA_IN(nrd), .NVM_ACK_IN(na), .RAM_RD_OUT(rr),
      .RAM_ADDR_OUT(rad), .RAM_RDATA_IN(rrd), .RAM_ACK_IN(ra), .SCAN_IN(scan), .OP_VALID_IN(opv),
      .OP_KIND_IN(kind), .OP_ADDR_IN(oa), .OP_DATA_IN(od), .AVS_ADDRESS_IN(ba), .AVS_READ_IN(rd),
      .AVS_WRITE_IN(wr), .AVS_BYTEENABLE_IN(be), .AVS_WRITEDATA_IN(bd), .AVS_READDATA_OUT(rdo),
      .AVS_WAITREQUEST_OUT(wq));
   cpl_mem_model u_cass (.clk_in(clk), .rd_in(cr), .wr_in(cw), .addr_in(cad), .wdata_in(cwd), .lat_in(lat),
      .rdata_out(crd), .ack_out(ca), .wr_n_out(cn));
   cpl_mem_model u_nvm (.clk_in(clk), .rd_in(nr), .wr_in(nw), .addr_in(nad), .wdata_in(nwd), .lat_in(lat),
      .rdata_out(nrd), .ack_out(na), .wr_n_out(nn));
   cpl_mem_model u_ram (.clk_in(clk), .rd_in(rr), .wr_in(1'b0), .addr_in(rad), .wdata_in(16'h0000),
      .lat_in(lat), .rdata_out(rrd), .ack_out(ra), .wr_n_out());
   task automatic report_and_stop;
      if (bad_count == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
      rd <= !w;
      wr <= w;
      ba <= a;
      bd <= d;
      be <= b;
      @(posedge clk);
      while (wq !== 1'b0) @(posedge clk);
      q = rdo;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic press(input logic w);
      if (w) wk <= 1'b1;
      else rk <= 1'b1;
      repeat (12) @(posedge clk);
      wk <= 1'b0;
      rk <= 1'b0;
      repeat (12) @(posedge clk);
   endtask
   task automatic wait_idle;
      for (k = 0; k < 300; k++) begin
         bus(0, cpl_pkg::REG_STATUS, 32'h0, 4'hf);
         if (q[2:0] === 3'h0) break;
      end
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      wl_p <= wl;
      if (wl !== wl_p) wtog <= wtog + 1;
      if (rl !== 1'b0) rhi <= rhi + 1;
      if (cyc == 20000) begin
         bad_count++;
         report_and_stop();
      end
   end
   initial begin
      u_cass.mem[0] = 16'h1234;
      u_cass.mem[1] = 16'h5678;
      u_nvm.mem[0] = 16'h1234;
      u_nvm.mem[1] = 16'h0000;
      u_ram.mem[0] = 16'hbeef;
      u_ram.mem[1] = 16'hcafe;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      bus(0, cpl_pkg::REG_XFER_LEN, 32'h0, 4'hf);
      chk(q, {17'h0, cpl_pkg::XFER_LEN_RST});
      bus(0, 8'h20, 32'h0, 4'hf);
      chk(q, 32'h0);
      bus(1, cpl_pkg::REG_XFER_LEN, 32'h2, 4'h3);
      run <= 1'b1;
      press(1);
      chk(wl, 1'b0);
      run <= 1'b0;
      press(1);
      chk({wl, rl}, 2'b10);
      press(0);
      chk({wl, rl}, 2'b00);
      press(0);
      chk({wl, rl}, 2'b01);
      press(1);
      chk({wl, rl}, 2'b00);
      lat <= 8'h0a;
      press(1);
      t0 = wtog;
      press(1);
      r0 = rhi;
      press(0);
      wait_idle;
      chk(wtog - t0 > 3, 1'b1);
      chk(rhi, r0);
      chk(wl, 1'b0);
      chk(u_nvm.mem[1], 16'h5678);
      chk(nn, 1);
      bus(0, cpl_pkg::REG_SKIPPED, 32'h0, 4'hf);
      chk(q, 32'h1);
      lock <= 1'b1;
      press(0);
      press(0);
      wait_idle;
      chk(cn, 0);
      chk(q[cpl_pkg::STAT_ERR], 1'b1);
      bus(1, cpl_pkg::REG_STATUS, 32'h300, 4'h2);
      lock <= 1'b0;
      press(0);
      press(0);
      wait_idle;
      chk({u_cass.mem[0], u_cass.mem[1]}, 32'hbeefcafe);
      chk(rl, 1'b0);
      u_ram.mem[0] = 16'h0f0f;
      disp <= 1'b1;
      press(1);
      press(1);
      chk(wl, 1'b0);
      bus(1, cpl_pkg::REG_CTRL, 32'h2, 4'h1);
      wait_idle;
      chk(u_cass.mem[0], 16'h0f0f);
      disp <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         t0 = nn;
         kind <= i[1:0];
         oa <= 15'(4 + i);
         od <= 16'(16'h00a0 + i);
         opv <= 1'b1;
         repeat (3) begin
            repeat (20) @(posedge clk);
            scan <= 1'b1;
            @(posedge clk);
            scan <= 1'b0;
         end
         repeat (20) @(posedge clk);
         opv <= 1'b0;
         repeat (20) @(posedge clk);
         chk(nn - t0, (i == 0) ? 3 : 1);
      end
      chk(u_nvm.mem[7], 16'h00a3);
      report_and_stop();
   end
endmodule // cpl_loader_bench
`default_nettype wire

// ===== tb/cpl_mem_model.sv
// cpl_mem_model: word memory that answers one request at a time after lat_in wait cycles.
// assumes level requests held until the one-cycle ack, all on one clock.
`timescale 1ns/1ps
`default_nettype none
module cpl_mem_model (
   input  wire logic        clk_in,
   input  wire logic        rd_in,
   input  wire logic        wr_in,
   input  wire logic [14:0] addr_in,
   input  wire logic [15:0] wdata_in,
   input  wire logic [7:0]  lat_in,
   output logic [15:0]      rdata_out,
   output logic             ack_out,
   output var int           wr_n_out
);
   logic [15:0] mem [16];
   logic [7:0]  cnt_q = 8'h00;
   initial begin
      ack_out = 1'b0;
      rdata_out = 16'h0000;
      wr_n_out = 0;
   end
   always @(posedge clk_in) begin
      ack_out <= 1'b0;
      rdata_out <= ~rdata_out;
      if (ack_out || !(rd_in || wr_in)) begin
         cnt_q <= 8'h00;
      end else if (cnt_q < lat_in) begin
         cnt_q <= cnt_q + 8'h01;
      end else begin
         ack_out <= 1'b1;
         if (wr_in) begin
            mem[addr_in[3:0]] <= wdata_in;
            wr_n_out <= wr_n_out + 1;
         end else begin
            rdata_out <= mem[addr_in[3:0]];
         end
      end
   end
endmodule // cpl_mem_model
`default_nettype wire
